// ---- verilog/can_xcvr_defs.vh ----
/*
 * constants for the transceiver mode controller: mode encodings, chip
 * modes, termination codes and timer figures.
 * assumes a 50 MHz system clock; included by bare name.
 */
`ifndef CAN_XCVR_DEFS_VH
`define CAN_XCVR_DEFS_VH

// transceiver mode field encodings (upper bit set = driver/receiver powered)
`define XM_OFF 2'h0
`define XM_WAKE 2'h1
`define XM_RXONLY 2'h2
`define XM_NORMAL 2'h3

// chip operating modes
`define CM_NORMAL 3'h0
`define CM_STOP 3'h1
`define CM_SLEEP 3'h2
`define CM_RESTART 3'h3
`define CM_FAILSAFE 3'h4

// termination selection
`define TERM_FLOAT 2'h0
`define TERM_HALF 2'h1
`define TERM_GND 2'h2
`define TERM_FIXED 2'h3

// times in ns at a 20 ns clock period
`define CLK_PERIOD_NS 20
`define ENABLE_SETTLE_NS 200000
`define WAKE_MIN_NS 500
`define WAKE_MAX_NS 1800000
`define SILENCE_NS 1000000
`define TX_DOM_TO_NS 2000000
`define BUS_DOM_TO_NS 4000000

// cycle counts of the times above, sized to the 24-bit timer width so
// no parameter default is cut; least times round up, longest round down
`define ENABLE_SETTLE_CYC 24'h002710
`define WAKE_MIN_CYC 24'h000019
`define WAKE_MAX_CYC 24'h015f90
`define SILENCE_CYC 24'h00c350
`define TX_DOM_TO_CYC 24'h0186a0
`define BUS_DOM_TO_CYC 24'h030d40

`endif

// ---- verilog/wake_pattern_detect.v ----
/*
 * wake pattern detector: dominant, recessive, dominant phases, each at
 * least the minimum and less than the maximum wake time.
 * assumes bus_dominant is a synchronous level; arm restarts the search.
 */
`timescale 1ns/1ps

module wake_pattern_detect #(
    parameter CW = 24,
    parameter [23:0] MIN_CYC = 24'h000019,
    parameter [23:0] MAX_CYC = 24'h015f90
) (
    input wire clock,
    input wire rst,
    input wire arm,
    input wire bus_dominant,
    output reg detected
);

localparam S_IDLE = 2'h0;
localparam S_DOM1 = 2'h1;
localparam S_REC = 2'h2;
localparam S_DOM2 = 2'h3;

reg [1:0] state_reg;
reg [CW-1:0] count_reg;
reg prev_reg;

////////////////////////////////////////////////////////////////////////
// phase timing; a short recessive phase restarts at the first dominant phase, any other phase out of window returns to idle
always @(posedge clock) begin
    if (rst || !arm) begin
        state_reg <= S_IDLE;
        count_reg <= {CW{1'b0}};
        prev_reg <= 1'b0;
        detected <= 1'b0;
    end else begin
        prev_reg <= bus_dominant;
        detected <= 1'b0;
        if (bus_dominant != prev_reg) begin
            count_reg <= {{(CW-1){1'b0}}, 1'b1};
        end else if (count_reg < MAX_CYC[CW-1:0]) begin
            count_reg <= count_reg + {{(CW-1){1'b0}}, 1'b1};
        end
        case (state_reg)
            S_IDLE: begin
                if (bus_dominant && !prev_reg) begin
                    state_reg <= S_DOM1;
                end
            end
            S_DOM1: begin
                if (count_reg >= MAX_CYC[CW-1:0]) begin
                    state_reg <= S_IDLE;
                end else if (!bus_dominant) begin
                    state_reg <= (count_reg >= MIN_CYC[CW-1:0]) ?
                        S_REC : S_IDLE;
                end
            end
            S_REC: begin
                if (count_reg >= MAX_CYC[CW-1:0]) begin
                    state_reg <= S_IDLE;
                end else if (bus_dominant) begin
                    state_reg <= (count_reg >= MIN_CYC[CW-1:0]) ?
                        S_DOM2 : S_DOM1;
                end
            end
            S_DOM2: begin
                // detection once the third phase reaches the minimum
                if (!bus_dominant) begin
                    state_reg <= S_IDLE;
                end else if (count_reg >= MIN_CYC[CW-1:0]) begin
                    detected <= 1'b1;
                    state_reg <= S_IDLE;
                end
            end
            default: begin
                state_reg <= S_IDLE;
            end
        endcase
    end
end

endmodule

// ---- verilog/can_transceiver_mode_control.v ----
/*
 * digital control of a high-speed CAN transceiver: modes, enabling
 * sequence, wake detection and signalling, termination, time-outs and
 * supply undervoltage handling.
 * assumes one 50 MHz clock, synchronous inputs, and mode requests from
 * an external serial-interface block as a one-cycle write strobe.
 */
`timescale 1ns/1ps
`include "can_xcvr_defs.vh"

// Contract
// R1 - start in Off after reset; Off accepted in every chip mode (code: in Fail-Safe the mode is forced to Wake-Capable instead)
// R2 - in Off, bus wake activity is dropped without any flag
// R3 - Normal mode accepted only while chip is in Normal mode
// R4 - controller keeps transmit high until the enabling time elapses
// R5 - early dominant ignored; send only after a recessive return
// R6 - Receive-Only disables driver, keeps receiving; chip Normal or Stop
// R7 - Wake-Capable allowed in Stop/Sleep/Restart/Normal; forced in Fail-Safe
// R8 - wake in Wake-Capable drives receive low until mode changes
// R9 - wake needs dominant, recessive, dominant, each within wake window
// R10 - mode field stays Wake-Capable after a bus wake
// R11 - after wake, detection disarmed until mode toggled away and back
// R12 - entering chip Stop, Sleep or Fail-Safe rearms wake detection
// R13 - wake in Stop/Normal: interrupt low, wake status set, mode kept
// R14 - wake in Stop enables watchdog if watchdog-on-wake bit set
// R15 - wake in Sleep/Fail-Safe goes Restart; Restart stays; no interrupt
// R16 - termination follows mode, supply undervoltage and wake state
// R17 - ground termination only after silence time on Wake entry
// R18 - transmit dominant too long forces recessive and sets bus fault
// R19 - bus dominant too long in Normal/Rx-Only sets bus fault
// R20 - bus clamp filter longer than transmit time-out
// R21 - undervoltage sets flag, disables driver, resumes automatically
// R22 - undervoltage monitored only when upper mode bit is one
// R23 - all timers are clock counters with configurable limits
module can_transceiver_mode_control #(
    parameter CW = 24,
    parameter [23:0] ENABLE_SETTLE_CYC = `ENABLE_SETTLE_CYC,
    parameter [23:0] WAKE_MIN_CYC = `WAKE_MIN_CYC,
    parameter [23:0] WAKE_MAX_CYC = `WAKE_MAX_CYC,
    parameter [23:0] SILENCE_CYC = `SILENCE_CYC,
    parameter [23:0] TX_DOM_TO_CYC = `TX_DOM_TO_CYC,
    parameter [23:0] BUS_DOM_TO_CYC = `BUS_DOM_TO_CYC
) (
    input wire clock,
    input wire rst,
    input wire [2:0] chip_mode,
    input wire mode_write,
    input wire [1:0] mode_wdata,
    input wire tx_data_in,
    input wire bus_rx_dominant,
    input wire transceiver_supply_low,
    input wire watchdog_on_bus_wake,
    input wire watchdog_enabled,
    input wire irq_clear,
    input wire wake_status_clear,
    input wire fault_clear,
    input wire uv_clear,
    output reg [1:0] mode_reg,
    output reg rx_data_out,
    output reg bus_drive_dominant,
    output reg [1:0] termination,
    output reg irq_out_n,
    output reg wake_status_reg,
    output reg bus_fault_flag,
    output reg supply_undervolt_flag,
    output reg watchdog_enable_req,
    output reg restart_req,
    output reg enable_done
);

reg [CW-1:0] en_cnt_reg;
reg tx_armed_reg;
reg armed_reg;
reg woken_reg;
reg [CW-1:0] sil_cnt_reg;
reg silence_done_reg;
reg [CW-1:0] tx_cnt_reg;
reg tx_timeout_reg;
reg [CW-1:0] bus_cnt_reg;
reg [2:0] chip_prev_reg;
reg mode_accept;
reg [1:0] mode_next;
wire wake_hit;
wire chip_enter_low;
wire driver_allowed;

////////////////////////////////////////////////////////////////////////
// mode request acceptance by chip mode
always @* begin
    mode_accept = 1'b0;
    case (mode_wdata)
        // R1 off everywhere
        `XM_OFF: mode_accept = 1'b1;
        // R3 normal gating
        `XM_NORMAL: mode_accept = (chip_mode == `CM_NORMAL);
        // R6 rx-only gating
        `XM_RXONLY: mode_accept = (chip_mode == `CM_NORMAL) ||
            (chip_mode == `CM_STOP);
        // R7 wake-capable gating
        `XM_WAKE: mode_accept = (chip_mode != `CM_FAILSAFE);
        default: mode_accept = 1'b0;
    endcase
end

// fail-safe overrides any software choice
always @* begin
    mode_next = mode_reg;
    if (chip_mode == `CM_FAILSAFE) begin
        // R7 forced wake-capable
        mode_next = `XM_WAKE;
    end else if (mode_write && mode_accept) begin
        mode_next = mode_wdata;
    end
end

// chip entering a low-power or fail-safe mode, seen as an edge
assign chip_enter_low = (chip_mode != chip_prev_reg) &&
    ((chip_mode == `CM_STOP) || (chip_mode == `CM_SLEEP) ||
    (chip_mode == `CM_FAILSAFE));

////////////////////////////////////////////////////////////////////////
// mode register, arming and wake state
always @(posedge clock) begin
    if (rst) begin
        // R1 off after reset
        mode_reg <= `XM_OFF;
        chip_prev_reg <= `CM_NORMAL;
        armed_reg <= 1'b1;
        woken_reg <= 1'b0;
    end else begin
        chip_prev_reg <= chip_mode;
        // R10 mode not altered by wake
        mode_reg <= mode_next;
        if (mode_next != `XM_WAKE) begin
            // R11 toggling away rearms
            armed_reg <= 1'b1;
            woken_reg <= 1'b0;
        end else if (chip_enter_low) begin
            // R12 rearm only; receive stays low until a mode change (R8)
            armed_reg <= 1'b1;
        end else if (wake_hit) begin
            // R11 disarm after wake
            armed_reg <= 1'b0;
            woken_reg <= 1'b1;
        end
    end
end

// R2 detector only runs in wake-capable while armed; off drops events
// R9 pattern check
wake_pattern_detect #(
    .CW(CW),
    .MIN_CYC(WAKE_MIN_CYC),
    .MAX_CYC(WAKE_MAX_CYC)
) u_wake (
    .clock(clock),
    .rst(rst),
    .arm(armed_reg && (mode_reg == `XM_WAKE) && (mode_next == `XM_WAKE)),
    .bus_dominant(bus_rx_dominant),
    .detected(wake_hit)
);

////////////////////////////////////////////////////////////////////////
// wake signalling; set wins over clear on every flag
always @(posedge clock) begin
    if (rst) begin
        irq_out_n <= 1'b1;
        wake_status_reg <= 1'b0;
        watchdog_enable_req <= 1'b0;
        restart_req <= 1'b0;
    end else begin
        watchdog_enable_req <= 1'b0;
        restart_req <= 1'b0;
        if (wake_hit) begin
            // R13 status always recorded
            wake_status_reg <= 1'b1;
            if ((chip_mode == `CM_STOP) || (chip_mode == `CM_NORMAL)) begin
                // R13 interrupt, chip mode kept
                irq_out_n <= 1'b0;
            end else if (irq_clear) begin
                irq_out_n <= 1'b1;
            end
            // R14 watchdog re-enable
            if ((chip_mode == `CM_STOP) && watchdog_on_bus_wake &&
                    !watchdog_enabled) begin
                watchdog_enable_req <= 1'b1;
            end
            // R15 restart request, no interrupt
            if ((chip_mode == `CM_SLEEP) || (chip_mode == `CM_FAILSAFE) ||
                    (chip_mode == `CM_RESTART)) begin
                restart_req <= 1'b1;
            end
        end else begin
            if (irq_clear) begin
                irq_out_n <= 1'b1;
            end
            if (wake_status_clear) begin
                wake_status_reg <= 1'b0;
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////
// enabling time and the early-dominant guard
always @(posedge clock) begin
    if (rst || !mode_reg[1]) begin
        en_cnt_reg <= {CW{1'b0}};
        enable_done <= 1'b0;
        tx_armed_reg <= 1'b0;
    end else begin
        // R23 settle counter
        if (en_cnt_reg < ENABLE_SETTLE_CYC[CW-1:0]) begin
            en_cnt_reg <= en_cnt_reg + {{(CW-1){1'b0}}, 1'b1};
        end else begin
            enable_done <= 1'b1;
        end
        // R5 need recessive after settle before first dominant
        if (enable_done && tx_data_in) begin
            tx_armed_reg <= 1'b1;
        end
    end
end

////////////////////////////////////////////////////////////////////////
// transmit dominant time-out, bus clamp and undervoltage
// the clamp limit defaults to twice the transmit limit so a stuck
// transmitter is caught by its own time-out first
always @(posedge clock) begin
    if (rst) begin
        tx_cnt_reg <= {CW{1'b0}};
        tx_timeout_reg <= 1'b0;
        bus_cnt_reg <= {CW{1'b0}};
        bus_fault_flag <= 1'b0;
        supply_undervolt_flag <= 1'b0;
    end else begin
        // R18 transmit time-out counter
        if (mode_reg == `XM_NORMAL && !tx_data_in) begin
            if (tx_cnt_reg < TX_DOM_TO_CYC[CW-1:0]) begin
                tx_cnt_reg <= tx_cnt_reg + {{(CW-1){1'b0}}, 1'b1};
            end else begin
                tx_timeout_reg <= 1'b1;
            end
        end else begin
            tx_cnt_reg <= {CW{1'b0}};
            tx_timeout_reg <= 1'b0;
        end
        // R19 R20 clamp counter with longer limit
        if (mode_reg[1] && bus_rx_dominant) begin
            if (bus_cnt_reg < BUS_DOM_TO_CYC[CW-1:0]) begin
                bus_cnt_reg <= bus_cnt_reg + {{(CW-1){1'b0}}, 1'b1};
            end
        end else begin
            bus_cnt_reg <= {CW{1'b0}};
        end
        // R18 R19 fault flag, set beats clear
        if ((tx_timeout_reg) ||
                (mode_reg[1] && bus_cnt_reg >= BUS_DOM_TO_CYC[CW-1:0])) begin
            bus_fault_flag <= 1'b1;
        end else if (fault_clear) begin
            bus_fault_flag <= 1'b0;
        end
        // R21 R22 undervoltage flag, monitored only with mode bit 1
        if (mode_reg[1] && transceiver_supply_low) begin
            supply_undervolt_flag <= 1'b1;
        end else if (uv_clear) begin
            supply_undervolt_flag <= 1'b0;
        end
    end
end

// R21 driver off during undervoltage, back when supply recovers
assign driver_allowed = (mode_reg == `XM_NORMAL) && tx_armed_reg &&
    !tx_timeout_reg && !transceiver_supply_low;

////////////////////////////////////////////////////////////////////////
// silence timer for ground termination on wake-capable entry
always @(posedge clock) begin
    if (rst || mode_reg != `XM_WAKE) begin
        sil_cnt_reg <= {CW{1'b0}};
        silence_done_reg <= 1'b0;
    end else if (bus_rx_dominant) begin
        // R17 bus activity restarts the silence timer
        sil_cnt_reg <= {CW{1'b0}};
    end else if (sil_cnt_reg < SILENCE_CYC[CW-1:0]) begin
        sil_cnt_reg <= sil_cnt_reg + {{(CW-1){1'b0}}, 1'b1};
    end else begin
        silence_done_reg <= 1'b1;
    end
end

////////////////////////////////////////////////////////////////////////
// registered pin outputs
always @(posedge clock) begin
    if (rst) begin
        rx_data_out <= 1'b1;
        bus_drive_dominant <= 1'b0;
        termination <= `TERM_FLOAT;
    end else begin
        // R18 R5 driver gated
        bus_drive_dominant <= driver_allowed && !tx_data_in;
        case (mode_reg)
            `XM_NORMAL: begin
                // R6 receive path follows bus
                rx_data_out <= !bus_rx_dominant;
                termination <= `TERM_HALF;
            end
            `XM_RXONLY: begin
                // R6 receive only, R16 fixed level on undervoltage
                rx_data_out <= !bus_rx_dominant;
                termination <= transceiver_supply_low ?
                    `TERM_FIXED : `TERM_HALF;
            end
            `XM_WAKE: begin
                // R8 receive held low after wake
                rx_data_out <= !woken_reg;
                // R16 R17 ground after silence, fixed after wake
                if (woken_reg) begin
                    termination <= `TERM_FIXED;
                end else if (silence_done_reg) begin
                    termination <= `TERM_GND;
                end else begin
                    termination <= `TERM_FLOAT;
                end
            end
            default: begin
                rx_data_out <= 1'b1;
                termination <= `TERM_FLOAT;
            end
        endcase
    end
end

endmodule

// ---- testbench/xcvr_mode_checker_sva.sv ----
/* port assertions for the transceiver mode controller.
 * assumes the bench clears irq and wake status before each wake test. */
`timescale 1ns/1ps
module xcvr_mode_checker #(
    parameter [23:0] SILENCE_CYC = 24'h000014,
    parameter [23:0] TX_DOM_TO_CYC = 24'h00001e,
    parameter [23:0] BUS_DOM_TO_CYC = 24'h00003c
) (
    input wire clock,
    input wire rst,
    input wire [2:0] chip_mode,
    input wire mode_write,
    input wire [1:0] mode_wdata,
    input wire tx_data_in,
    input wire bus_rx_dominant,
    input wire [1:0] mode_reg,
    input wire rx_data_out,
    input wire bus_drive_dominant,
    input wire [1:0] termination,
    input wire irq_out_n,
    input wire wake_status_reg,
    input wire bus_fault_flag
);
default clocking cb @(posedge clock); endclocking
default disable iff (rst);
reg [23:0] tx_cnt, bus_cnt, wk_age;
////////////////////////////////////////
// run lengths: tx dominant, bus dominant, cycles spent in wake mode
always @(posedge clock) begin
    if (rst) begin
        tx_cnt <= 24'h0;
        bus_cnt <= 24'h0;
        wk_age <= 24'h0;
    end else begin
        tx_cnt <= (mode_reg == 2'h3 && !tx_data_in) ? tx_cnt + 24'h1 : 24'h0;
        bus_cnt <= (mode_reg[1] && bus_rx_dominant) ? bus_cnt + 24'h1 : 24'h0;
        wk_age <= (mode_reg == 2'h1) ? wk_age + 24'h1 : 24'h0;
    end
end
// outputs lag the mode by one edge, so conditions must hold twice
sequence s_two(x); x [*2]; endsequence
property p_reset_off;
    $fell(rst) |-> mode_reg == 2'h0 && termination == 2'h0 && irq_out_n;
endproperty
property p_norm_refused;
    mode_write && mode_wdata == 2'h3 && chip_mode inside {3'h1, 3'h2, 3'h3}
    |=> $stable(mode_reg);
endproperty
property p_failsafe;
    s_two(chip_mode == 3'h4) |-> mode_reg == 2'h1;
endproperty
property p_drv_off;
    s_two(mode_reg != 2'h3) |-> !bus_drive_dominant;
endproperty
property p_tx_to;
    tx_cnt > TX_DOM_TO_CYC + 24'h2 |-> !bus_drive_dominant && bus_fault_flag;
endproperty
property p_bus_to;
    bus_cnt > BUS_DOM_TO_CYC + 24'h2 |-> bus_fault_flag && $stable(mode_reg);
endproperty
property p_off_quiet;
    mode_reg == 2'h0 && !mode_write && !wake_status_reg |=> !wake_status_reg;
endproperty
property p_rx_hold;
    mode_reg == 2'h1 && $past(mode_reg) == 2'h1 && !mode_write &&
    !rx_data_out |=> !rx_data_out;
endproperty
property p_irq;
    $rose(wake_status_reg) |-> irq_out_n == (chip_mode > 3'h1);
endproperty
property p_silence;
    termination == 2'h2 |-> wk_age >= SILENCE_CYC;
endproperty
a_reset_off: assert property (p_reset_off) else $error("not off");
a_norm_refused: assert property (p_norm_refused) else $error("taken");
a_failsafe: assert property (p_failsafe) else $error("not forced");
a_drv_off: assert property (p_drv_off) else $error("driving");
a_tx_to: assert property (p_tx_to) else $error("tx stuck");
a_bus_to: assert property (p_bus_to) else $error("no clamp fault");
a_off_quiet: assert property (p_off_quiet) else $error("woke");
a_rx_hold: assert property (p_rx_hold) else $error("rx released");
a_irq: assert property (p_irq) else $error("irq wrong");
a_silence: assert property (p_silence) else $error("early gnd");
endmodule
bind can_transceiver_mode_control xcvr_mode_checker #(
    .SILENCE_CYC(SILENCE_CYC), .TX_DOM_TO_CYC(TX_DOM_TO_CYC),
    .BUS_DOM_TO_CYC(BUS_DOM_TO_CYC)
) chk (
    .clock, .rst, .chip_mode, .mode_write, .mode_wdata, .tx_data_in,
    .bus_rx_dominant, .mode_reg, .rx_data_out, .bus_drive_dominant,
    .termination, .irq_out_n, .wake_status_reg, .bus_fault_flag
);

// ---- testbench/can_bus_model.sv ----
/* far side: the bus as the receiver sees it, this node's driver or a
 * remote node that the bench steers.
 * assumes its tasks are called at a falling clock edge. */
`timescale 1ns/1ps
module can_bus_model (
    input wire clock,
    input wire drive_dominant,
    output wire bus_dominant
);
reg remote = 1'b0;
////////////////////////////////////////
// dominant wins on the wire, whichever node pulls
assign bus_dominant = drive_dominant | remote;
task automatic hold(input reg d, input integer n);
    remote = d;
    repeat (n) @(negedge clock);
endtask
// the long idle after the pattern also resets a half-seen pattern
task automatic wake_seq(input integer d1, input integer r, input integer d2);
    hold(1'b1, d1);
    hold(1'b0, r);
    hold(1'b1, d2);
    hold(1'b0, 15);
endtask
endmodule

// ---- testbench/tb_top.sv ----
/* bench for the transceiver mode controller: mode table, enabling,
 * time-outs, undervoltage and wake signalling per chip mode.
 * assumes short timer values so each wait is tens of cycles. */
`timescale 1ns/1ps
module tb_top;
localparam [23:0] SET = 24'h000014;
localparam [23:0] SIL = 24'h000014;
localparam [23:0] TXTO = 24'h00001e;
localparam [23:0] BUSTO = 24'h00003c;
reg clock = 0, rst = 1, wr_en = 0, tx = 1, uv_low = 0;
reg irq_clr = 0, ws_clr = 0, f_clr = 0, uv_clr = 0;
reg wd_cfg = 1, wd_on = 0;
reg [2:0] cm = 3'h0;
reg [1:0] wdata = 2'h0;
wire [1:0] mode, term;
wire rx, drv, irq_n, ws, fault, uvf, wd_req, rs_req, en_done, bus_dom;
integer mismatches = 0, n_compared = 0, seed = 97, cycles = 0;
integer n_wd = 0, n_rs = 0, i, k, m;
can_transceiver_mode_control #(
    .ENABLE_SETTLE_CYC(SET), .WAKE_MIN_CYC(24'h000003),
    .WAKE_MAX_CYC(24'h00000a), .SILENCE_CYC(SIL),
    .TX_DOM_TO_CYC(TXTO), .BUS_DOM_TO_CYC(BUSTO)
) DUT (
    .clock(clock), .rst(rst), .chip_mode(cm), .mode_write(wr_en),
    .mode_wdata(wdata), .tx_data_in(tx), .bus_rx_dominant(bus_dom),
    .transceiver_supply_low(uv_low), .watchdog_on_bus_wake(wd_cfg),
    .watchdog_enabled(wd_on), .irq_clear(irq_clr),
    .wake_status_clear(ws_clr), .fault_clear(f_clr), .uv_clear(uv_clr),
    .mode_reg(mode), .rx_data_out(rx), .bus_drive_dominant(drv),
    .termination(term), .irq_out_n(irq_n), .wake_status_reg(ws),
    .bus_fault_flag(fault), .supply_undervolt_flag(uvf),
    .watchdog_enable_req(wd_req), .restart_req(rs_req), .enable_done(en_done)
);
can_bus_model bus (.clock(clock), .drive_dominant(drv), .bus_dominant(bus_dom));
////////////////////////////////////////
// clock, cycle ceiling and pulse counters
always #10 clock = ~clock;
always @(posedge clock) begin
    cycles = cycles + 1;
    n_wd = n_wd + (wd_req === 1'b1);
    n_rs = n_rs + (rs_req === 1'b1);
    if (cycles == 5000) begin
        mismatches = mismatches + 1;
        $display("cycle limit reached");
        results;
    end
end
// which mode a write from off leaves behind
function [1:0] exp_mode(input [2:0] c, input [1:0] w);
    if (c == 3'h4)
        exp_mode = 2'h1;
    else if ((w == 2'h3 && c != 3'h0) || (w == 2'h2 && c > 3'h1))
        exp_mode = 2'h0;
    else
        exp_mode = w;
endfunction
task automatic check(input string what, input [7:0] seen, input [7:0] exp);
    n_compared = n_compared + 1;
    if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
endtask
task automatic cyc(input integer n);
    repeat (n) @(negedge clock);
endtask
// an idle cycle after the strobe keeps back-to-back writes apart
task automatic wr(input [1:0] w);
    wdata = w;
    wr_en = 1;
    cyc(1);
    wr_en = 0;
    cyc(1);
endtask
task automatic clr;
    {irq_clr, ws_clr, f_clr, uv_clr} = 4'hf;
    cyc(1);
    {irq_clr, ws_clr, f_clr, uv_clr} = 4'h0;
endtask
task automatic done(input string t);
    $display("test %s ended, mismatches %0d", t, mismatches);
endtask
task results;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
        $display("== PASSED ==");
    else
        $display("== FAILED ==");
    $finish;
endtask
initial begin
    cyc(12);
    rst = 0;
    cyc(1);
    check("mode", mode, 0);
    check("term", term, 0);
    check("irq_n", irq_n, 1);
    for (i = 0; i < 20; i = i + 1) begin
        cm = i[4:2];
        wr(2'h0);
        wr(i[1:0]);
        check("mode", mode, exp_mode(cm, i[1:0]));
    end
    done("mode table");
    cm = 3'h0;
    wr(2'h0);
    tx = 0;
    wr(2'h3);
    cyc(SET + 5);
    check("drv", drv, 0);
    check("en_done", en_done, 1);
    // recessive return first, then random traffic
    for (k = 0; k < 200; k = k + 1) begin
        tx = (k == 0) | $random(seed);
        cyc(1);
        check("drv", drv, !tx);
    end
    done("enabling");
    clr;
    tx = 0;
    cyc(TXTO + 5);
    check("drv", drv, 0);
    check("fault", fault, 1);
    check("mode", mode, 3);
    tx = 1;
    clr;
    tx = 0;
    cyc(2);
    check("drv", drv, 1);
    tx = 1;
    clr;
    bus.hold(1'b1, BUSTO + 5);
    check("fault", fault, 1);
    check("mode", mode, 3);
    bus.hold(1'b0, 2);
    done("time-outs");
    // low supply blocks the driver, then recovers
    clr;
    tx = 0;
    uv_low = 1;
    cyc(5);
    check("uv", uvf, 1);
    check("drv", drv, 0);
    uv_low = 0;
    tx = 1;
    cyc(2);
    tx = 0;
    cyc(2);
    check("drv", drv, 1);
    tx = 1;
    wr(2'h2);
    uv_low = 1;
    cyc(3);
    check("term", term, 3);
    uv_low = 0;
    cyc(3);
    check("term", term, 1);
    wr(2'h0);
    clr;
    uv_low = 1;
    cyc(5);
    check("uv", uvf, 0);
    uv_low = 0;
    done("undervoltage");
    bus.wake_seq(5, 5, 5);
    check("wake", ws, 0);
    // stop and fail-safe entries rearm without a mode toggle
    // passes 5 and 6 repeat stop with the watchdog inputs varied
    for (i = 0; i < 7; i = i + 1) begin
        cm = (i > 4) ? 3'h1 : i[2:0];
        wd_cfg = (i != 6);
        wd_on = (i == 5);
        if (i != 1 && i != 4) begin
            wr(2'h0);
            wr(2'h1);
            cyc(SIL + 3);
            check("term", term, 2);
            bus.wake_seq(2, 5, 5);
            bus.wake_seq(12, 5, 5);
            check("wake", ws, 0);
        end
        clr;
        // rearm alone leaves the receive output low
        if (i == 1 || i == 4) begin
            cyc(2);
            check("rx", rx, 0);
        end
        k = n_rs;
        m = n_wd;
        bus.wake_seq(5, 5, 5);
        check("wake", ws, 1);
        check("irq_n", irq_n, cm > 3'h1);
        check("rx", rx, 0);
        check("mode", mode, 1);
        check("term", term, 3);
        check("wd_req", n_wd - m, i == 1);
        if (cm != 3'h3)
            check("restart", n_rs - k, cm > 3'h1);
        clr;
        bus.wake_seq(5, 5, 5);
        check("rearm", ws, 0);
    end
    done("wake");
    results;
end
endmodule
